// file: fpes_pkg.sv
// Shared constants and types of the flash program and erase sequencer
package fpes_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Register port decode
    localparam int ADDR_W = 21;
    localparam int REG_SEL_BIT = 20;
    localparam logic [7:0] OFF_MODE = 8'h00;
    localparam logic [7:0] OFF_CMD = 8'h04;
    localparam logic [7:0] OFF_STATUS = 8'h08;
    localparam logic [7:0] OFF_RESULT = 8'h0c;

    ////////////////////////////////////////////////////////////////////////////
    // Field positions
    localparam int ST_DONE_BIT = 0;
    localparam int ST_BAD_BIT = 1;
    localparam int ST_LOCK_BIT = 2;
    localparam int MODE_IE_BIT = 0;
    localparam int FWS_W = 4;
    localparam int MODE_FWS_LSB = 8;
    localparam int CMD_KEY_MSB = 31;
    localparam int CMD_KEY_LSB = 24;
    localparam int ARG_MSB = 23;
    localparam int ARG_LSB = 8;
    localparam int CODE_MSB = 7;
    localparam int CODE_LSB = 0;
    localparam int PAGE_W = 16;

    // Arbitrary key value
    localparam logic [7:0] CMD_KEY = 8'ha5;
    // Arbitrary interface description word
    localparam logic [31:0] IFACE_DESCR = 32'h0000_1234;

    ////////////////////////////////////////////////////////////////////////////
    // Command codes
    localparam logic [7:0] CODE_DESC = 8'h00;
    localparam logic [7:0] CODE_PROG = 8'h01;
    localparam logic [7:0] CODE_PROG_LOCK = 8'h02;
    localparam logic [7:0] CODE_ERASE_PROG = 8'h03;
    localparam logic [7:0] CODE_ERASE_PROG_LOCK = 8'h04;
    localparam logic [7:0] CODE_FULL_ERASE = 8'h05;

    ////////////////////////////////////////////////////////////////////////////
    // Descriptor word indices and latch granularity
    localparam int DW_IFACE = 0;
    localparam int DW_TOTAL = 1;
    localparam int DW_PAGE = 2;
    localparam int DW_PLANES = 3;
    localparam int DW_PLANE0 = 4;
    localparam int QUAD_SHIFT = 2;

    typedef enum logic [1:0] {S_IDLE, S_ERASE, S_PROG, S_FIN} fpes_state_t;

endpackage

// file: fpes_lbuf_if.sv
// Link between the sequencer and its page latch buffer
`timescale 1ns/1ps
`default_nettype none
interface fpes_lbuf_if #(parameter int IDXW = 6, parameter int FWSW = 4);
    logic wr_valid;
    logic [IDXW-1:0] wr_idx;
    logic [31:0] wr_data;
    logic [FWSW-1:0] fws;
    logic [IDXW-1:0] rd_idx;
    logic [31:0] rd_data;
    logic rd_dirty;
    logic clr_dirty;
    modport ctrl (output wr_valid, wr_idx, wr_data, fws, rd_idx, clr_dirty,
                  input rd_data, rd_dirty);
    modport store (input wr_valid, wr_idx, wr_data, fws, rd_idx, clr_dirty,
                   output rd_data, rd_dirty);
endinterface
`default_nettype wire

// file: fpes_latch.sv
// One-page write latch with wait-state delay line and 128-bit dirty tracking
`timescale 1ns/1ps
`default_nettype none
module fpes_latch
    import fpes_pkg::*;
#(
    parameter int WORDS = 64,
    parameter int IDXW = 6
) (
    input wire logic clk,
    input wire logic rst,
    fpes_lbuf_if.store lb
);
    localparam int DEPTH = 2 ** FWS_W;
    localparam int QUADS = WORDS >> QUAD_SHIFT;
    localparam int QW = IDXW - QUAD_SHIFT;

    typedef struct packed {
        logic [DEPTH-1:0] sv;
        logic [DEPTH-1:0][IDXW-1:0] si;
        logic [DEPTH-1:0][31:0] sd;
        logic [WORDS-1:0][31:0] mem;
        logic [QUADS-1:0] dirty;
        logic [31:0] rd_data;
        logic rd_dirty;
    } fpes_lat_t;

    fpes_lat_t r;
    fpes_lat_t next_r;

    assign lb.rd_data = r.rd_data;
    assign lb.rd_dirty = r.rd_dirty;

    ////////////////////////////////////////////////////////////////////////////
    always_comb begin
        next_r = r;
        next_r.sv[0] = lb.wr_valid;
        next_r.si[0] = lb.wr_idx;
        next_r.sd[0] = lb.wr_data;
        for (int i = 1; i < DEPTH; i++) begin
            next_r.sv[i] = r.sv[i-1];
            next_r.si[i] = r.si[i-1];
            next_r.sd[i] = r.sd[i-1];
        end
        // Dirty marks drop after a program pass
        if (lb.clr_dirty) begin
            next_r.dirty = '0;
        end
        // Commit when the word has waited as long as a read would
        if (r.sv[lb.fws]) begin
            next_r.mem[r.si[lb.fws]] = r.sd[lb.fws];
            next_r.dirty[r.si[lb.fws][IDXW-1:QUAD_SHIFT]] = 1'b1;
        end
        next_r.rd_data = r.mem[lb.rd_idx];
        next_r.rd_dirty = r.dirty[lb.rd_idx[IDXW-1:IDXW-QW]];
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

endmodule
`default_nettype wire

// file: fpes_seq.sv
// Flash command sequencer: registers, descriptor, program, erase and locks
`timescale 1ns/1ps
`default_nettype none
// How it works
// - Descriptor fetch done shows word zero
// - Each result read advances descriptor word
// - Past last word, result reads zero
// - Words: interface, total, page, planes, plane sizes
// - Then lock count, then lock region sizes
// - Erase-program commands erase page then program
// - Lock variants set region lock after programming
// - Latch aliases every page across memory area
// - Latch writes wait configured read wait states
// - Program starts at command, done clears
// - Program completion sets done flag
// - Done rise raises interrupt when enabled
// - Wrong key ignored, bad command flag set
// - Locked page program refused, lock error set
// - Partial programming in 128-bit aligned steps
// - Full plane erase or page erase supported
// - Erase starts at command, done at end
// - Any locked page rejects whole erase
// - Command codes zero through five decoded
// - Key in top eight bits required
// - Command write clears done and result
// - Status read clears error flags
module fpes_seq
    import fpes_pkg::*;
#(
    parameter int PAGE_BYTES = 256,
    parameter int PLANE_BYTES = 65536,
    parameter int NPLANES = 1,
    parameter int NLOCK = 16,
    parameter int ERASE_CYC = 64
) (
    input wire logic SYS_CLK,
    input wire logic SYS_RST,
    input wire logic [ADDR_W-1:0] ADDR,
    input wire logic [31:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [31:0] RDATA,
    output logic IRQ,
    output logic [PAGE_W-1:0] FL_PAGE,
    output logic FL_ERASE_PAGE,
    output logic FL_ERASE_ALL,
    output logic FL_PROG_WE,
    output logic [$clog2(PAGE_BYTES/4)-1:0] FL_PROG_ADDR,
    output logic [31:0] FL_PROG_DATA,
    output logic LOCK_REGION_BYTES_WORD_SET,
    output logic [$clog2(NLOCK)-1:0] LOCK_REGION_BYTES_WORD_REGION
);
    localparam int WORDS = PAGE_BYTES / 4;
    localparam int IDXW = $clog2(WORDS);
    localparam int LRW = $clog2(NLOCK);
    localparam int NPAGES = PLANE_BYTES * NPLANES / PAGE_BYTES;
    localparam int PAGES_PER_LOCK = NPAGES / NLOCK;
    localparam int LOCK_BYTES = PLANE_BYTES * NPLANES / NLOCK;
    localparam int DESC_LEN = DW_PLANE0 + NPLANES + 1 + NLOCK;
    localparam logic [IDXW-1:0] LAST_IDX = IDXW'(WORDS - 1);
    localparam logic [15:0] ERASE_LOAD = 16'(ERASE_CYC - 1);
    localparam int ERASE_SPAN = ERASE_CYC + 3;

    typedef struct packed {
        fpes_state_t state;
        logic done;
        logic bad;
        logic lockerr;
        logic ie;
        logic [FWS_W-1:0] fws;
        logic desc_on;
        logic [7:0] res_idx;
        logic [31:0] rdata;
        logic irq;
        logic [NLOCK-1:0] locks;
        logic [7:0] op;
        logic [PAGE_W-1:0] page;
        logic [15:0] cnt;
        logic [IDXW-1:0] widx;
        logic issued;
        logic pv;
        logic [IDXW-1:0] pidx;
        logic clr;
        logic fl_erase_page;
        logic fl_erase_all;
        logic fl_we;
        logic [IDXW-1:0] fl_addr;
        logic [31:0] fl_data;
        logic lock_region_bytes_word_set;
        logic [LRW-1:0] fl_region;
    } fpes_st_t;

    fpes_st_t r;
    fpes_st_t next_r;

    ////////////////////////////////////////////////////////////////////////////
    // Decoding helpers
    function automatic logic [LRW-1:0] region_of(input logic [PAGE_W-1:0] pg);
        logic [PAGE_W-1:0] q;
        q = pg / PAGE_W'(PAGES_PER_LOCK);
        return q[LRW-1:0];
    endfunction

    function automatic logic is_prog(input logic [7:0] c);
        return (c >= CODE_PROG) && (c <= CODE_ERASE_PROG_LOCK);
    endfunction

    function automatic logic [31:0] desc_word(input logic [7:0] i);
        int k;
        k = int'(i);
        if (k == DW_IFACE) return IFACE_DESCR;
        if (k == DW_TOTAL) return 32'(PLANE_BYTES * NPLANES);
        if (k == DW_PAGE) return 32'(PAGE_BYTES);
        if (k == DW_PLANES) return 32'(NPLANES);
        if (k < DW_PLANE0 + NPLANES) return 32'(PLANE_BYTES);
        if (k == DW_PLANE0 + NPLANES) return 32'(NLOCK);
        if (k < DESC_LEN) return 32'(LOCK_BYTES);
        return '0;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Bus decode
    logic is_reg;
    logic [7:0] off;
    logic cmd_wr;
    logic rd_res;
    logic rd_stat;
    logic key_ok;
    logic [7:0] code;
    logic [PAGE_W-1:0] arg;
    logic code_ok;
    logic arg_ok;
    logic valid;
    logic locked_tgt;

    assign is_reg = ADDR[REG_SEL_BIT];
    assign off = ADDR[7:0];
    assign cmd_wr = WR && is_reg && (off == OFF_CMD);
    assign rd_res = RD && is_reg && (off == OFF_RESULT);
    assign rd_stat = RD && is_reg && (off == OFF_STATUS);
    assign key_ok = WDATA[CMD_KEY_MSB:CMD_KEY_LSB] == CMD_KEY;
    assign code = WDATA[CODE_MSB:CODE_LSB];
    assign arg = WDATA[ARG_MSB:ARG_LSB];
    assign code_ok = code <= CODE_FULL_ERASE;
    assign arg_ok = !is_prog(code) || (arg < PAGE_W'(NPAGES));
    // A command may land while completion is being flagged
    assign valid = key_ok && code_ok && arg_ok && (r.state == S_IDLE || r.state == S_FIN);
    assign locked_tgt = (code == CODE_FULL_ERASE) ? (|r.locks) : r.locks[region_of(arg)];

    ////////////////////////////////////////////////////////////////////////////
    // Page latch: any page-aligned alias in the memory area selects a word
    fpes_lbuf_if #(.IDXW(IDXW), .FWSW(FWS_W)) lb ();

    assign lb.wr_valid = WR && !is_reg;
    assign lb.wr_idx = ADDR[IDXW+1:2];
    assign lb.wr_data = WDATA;
    assign lb.fws = r.fws;
    assign lb.rd_idx = r.widx;
    assign lb.clr_dirty = r.clr;

    fpes_latch #(.WORDS(WORDS), .IDXW(IDXW)) u_latch (
        .clk(SYS_CLK),
        .rst(SYS_RST),
        .lb(lb)
    );

    ////////////////////////////////////////////////////////////////////////////
    always_comb begin
        next_r = r;
        next_r.rdata = '0;
        next_r.fl_erase_page = 1'b0;
        next_r.fl_erase_all = 1'b0;
        next_r.fl_we = 1'b0;
        next_r.lock_region_bytes_word_set = 1'b0;
        next_r.clr = 1'b0;

        if (WR && is_reg && off == OFF_MODE) begin
            next_r.ie = WDATA[MODE_IE_BIT];
            next_r.fws = WDATA[MODE_FWS_LSB+FWS_W-1:MODE_FWS_LSB];
        end

        // Read data stands for one cycle only; unmapped reads return zero
        if (RD && is_reg) begin
            if (off == OFF_MODE) begin
                next_r.rdata[MODE_IE_BIT] = r.ie;
                next_r.rdata[MODE_FWS_LSB+FWS_W-1:MODE_FWS_LSB] = r.fws;
            end else if (off == OFF_STATUS) begin
                next_r.rdata[ST_DONE_BIT] = r.done;
                next_r.rdata[ST_BAD_BIT] = r.bad;
                next_r.rdata[ST_LOCK_BIT] = r.lockerr;
                next_r.bad = 1'b0;
                next_r.lockerr = 1'b0;
            end else if (off == OFF_RESULT && r.desc_on) begin
                next_r.rdata = desc_word(r.res_idx);
                next_r.res_idx = r.res_idx + 8'h01;
                if (int'(r.res_idx) == DESC_LEN - 1) begin
                    next_r.desc_on = 1'b0;
                end
            end
        end

        unique case (r.state)
            S_IDLE: begin
            end
            S_ERASE: begin
                if (r.cnt == '0) begin
                    next_r.state = (r.op == CODE_FULL_ERASE) ? S_FIN : S_PROG;
                    next_r.widx = '0;
                    next_r.issued = 1'b0;
                    next_r.pv = 1'b0;
                end else begin
                    next_r.cnt = r.cnt - 16'h0001;
                end
            end
            S_PROG: begin
                // Latch read has one cycle of latency, so pidx trails widx
                next_r.pv = !r.issued;
                next_r.pidx = r.widx;
                if (!r.issued) begin
                    if (r.widx == LAST_IDX) begin
                        next_r.issued = 1'b1;
                    end else begin
                        next_r.widx = r.widx + IDXW'(1);
                    end
                end
                if (r.pv) begin
                    // Only 128-bit groups touched since the last pass go out
                    next_r.fl_we = lb.rd_dirty;
                    next_r.fl_addr = r.pidx;
                    next_r.fl_data = lb.rd_data;
                    if (r.pidx == LAST_IDX) begin
                        if (r.op == CODE_PROG_LOCK || r.op == CODE_ERASE_PROG_LOCK) begin
                            next_r.locks[region_of(r.page)] = 1'b1;
                            next_r.lock_region_bytes_word_set = 1'b1;
                            next_r.fl_region = region_of(r.page);
                        end
                        next_r.clr = 1'b1;
                        next_r.state = S_FIN;
                    end
                end
            end
            S_FIN: begin
                next_r.done = 1'b1;
                next_r.state = S_IDLE;
            end
        endcase

        if (cmd_wr) begin
            next_r.done = 1'b0;
            next_r.desc_on = 1'b0;
            next_r.res_idx = '0;
            if (!valid) begin
                next_r.bad = 1'b1;
                // An idle block must still flag completion, or done would stay low
                if (r.state == S_IDLE || r.state == S_FIN) begin
                    next_r.state = S_FIN;
                end
            end else if (code == CODE_DESC) begin
                next_r.desc_on = 1'b1;
                next_r.state = S_FIN;
            end else if (locked_tgt) begin
                next_r.lockerr = 1'b1;
                next_r.state = S_FIN;
            end else begin
                next_r.op = code;
                next_r.page = arg;
                next_r.widx = '0;
                next_r.issued = 1'b0;
                next_r.pv = 1'b0;
                next_r.cnt = ERASE_LOAD;
                if (code == CODE_FULL_ERASE) begin
                    next_r.fl_erase_all = 1'b1;
                    next_r.state = S_ERASE;
                end else if (code == CODE_ERASE_PROG || code == CODE_ERASE_PROG_LOCK) begin
                    next_r.fl_erase_page = 1'b1;
                    next_r.state = S_ERASE;
                end else begin
                    next_r.state = S_PROG;
                end
            end
        end

        next_r.irq = next_r.done && next_r.ie;
    end

    always_ff @(posedge SYS_CLK) begin
        if (SYS_RST) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign RDATA = r.rdata;
    assign IRQ = r.irq;
    assign FL_PAGE = r.page;
    assign FL_ERASE_PAGE = r.fl_erase_page;
    assign FL_ERASE_ALL = r.fl_erase_all;
    assign FL_PROG_WE = r.fl_we;
    assign FL_PROG_ADDR = r.fl_addr;
    assign FL_PROG_DATA = r.fl_data;
    assign LOCK_REGION_BYTES_WORD_SET = r.lock_region_bytes_word_set;
    assign LOCK_REGION_BYTES_WORD_REGION = r.fl_region;

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge SYS_CLK);
    endclocking
    default disable iff (SYS_RST);

    sequence s_descriptor_fetch_cmd_wr;
        cmd_wr && valid && code == CODE_DESC;
    endsequence
    sequence s_quiet;
        !cmd_wr && !rd_res;
    endsequence
    sequence s_erase_all_wr;
        cmd_wr && valid && code == CODE_FULL_ERASE;
    endsequence

    property p_descriptor_fetch_cmd_done;
        s_descriptor_fetch_cmd_wr ##1 s_quiet |=> r.done && r.desc_on && r.res_idx == 8'h00;
    endproperty
    a_descriptor_fetch_cmd_done: assert property (p_descriptor_fetch_cmd_done) else $error("descriptor done wrong");

    property p_desc_adv;
        rd_res && r.desc_on |=> r.res_idx == $past(r.res_idx) + 8'h01
            && RDATA == desc_word($past(r.res_idx));
    endproperty
    a_desc_adv: assert property (p_desc_adv) else $error("descriptor did not advance");

    property p_desc_zero;
        rd_res && !r.desc_on |=> RDATA == 32'h0000_0000;
    endproperty
    a_desc_zero: assert property (p_desc_zero) else $error("result not zero");

    property p_cmd_clr;
        cmd_wr |=> !r.done && r.res_idx == 8'h00
            && r.desc_on == $past(valid && code == CODE_DESC);
    endproperty
    a_cmd_clr: assert property (p_cmd_clr) else $error("command write did not clear");

    property p_badkey;
        cmd_wr && !key_ok |=> r.bad && !FL_ERASE_PAGE && !FL_ERASE_ALL
            && r.page == $past(r.page);
    endproperty
    a_badkey: assert property (p_badkey) else $error("bad key not flagged");

    property p_lock_prog;
        cmd_wr && valid && is_prog(code) && locked_tgt |=>
            r.lockerr && !FL_ERASE_PAGE ##1 r.done && !FL_PROG_WE;
    endproperty
    a_lock_prog: assert property (p_lock_prog) else $error("locked program not refused");

    property p_irq;
        $rose(r.done) && r.ie |-> IRQ;
    endproperty
    a_irq: assert property (p_irq) else $error("no interrupt on done");

    property p_rd_clr;
        rd_stat |=> !r.bad && !r.lockerr;
    endproperty
    a_rd_clr: assert property (p_rd_clr) else $error("status read did not clear");

    property p_erase_end;
        (s_erase_all_wr and !locked_tgt) ##1 (!cmd_wr)[*1] |->
            FL_ERASE_ALL ##[1:ERASE_SPAN] $rose(r.done);
    endproperty
    a_erase_end: assert property (p_erase_end) else $error("erase did not finish");

    property p_erase_lock;
        (s_erase_all_wr and locked_tgt) |=> r.lockerr && !FL_ERASE_ALL && r.state == S_FIN;
    endproperty
    a_erase_lock: assert property (p_erase_lock) else $error("locked erase not rejected");

    property p_lock_set;
        LOCK_REGION_BYTES_WORD_SET |-> r.locks[LOCK_REGION_BYTES_WORD_REGION] && r.state == S_FIN;
    endproperty
    a_lock_set: assert property (p_lock_set) else $error("lock bit not set");

    property p_prog_start;
        cmd_wr && valid && code == CODE_PROG && !locked_tgt |=> r.state == S_PROG && !r.done;
    endproperty
    a_prog_start: assert property (p_prog_start) else $error("program did not start");

endmodule
`default_nettype wire

// file: fpes_flash_model.sv
// Behavioural flash array that records what the sequencer asks of it
`timescale 1ns/1ps
`default_nettype none
module fpes_flash_model (
    input wire logic clk,
    input wire logic rst,
    input wire logic erase_page,
    input wire logic erase_all,
    input wire logic prog_we,
    input wire logic [5:0] prog_addr,
    input wire logic [31:0] prog_data,
    input wire logic lock_set,
    input wire logic [3:0] lock_region
);
    logic [31:0] mem [64];
    int n_prog;
    int n_erp;
    int n_era;
    int n_lock;
    logic [3:0] last_region;
    ////////////////////////////////////////////////////////////////////////////
    // Counts and stores programmed words; the bench decides whether each is right
    always_ff @(posedge clk) begin
        if (rst) begin
            n_prog <= 0;
            n_erp <= 0;
            n_era <= 0;
            n_lock <= 0;
            last_region <= 4'h0;
        end else begin
            if (prog_we) begin
                mem[prog_addr] <= prog_data;
                n_prog <= n_prog + 1;
            end
            if (erase_page) n_erp <= n_erp + 1;
            if (erase_all) n_era <= n_era + 1;
            if (lock_set) begin
                n_lock <= n_lock + 1;
                last_region <= lock_region;
            end
        end
    end
endmodule
`default_nettype wire

// file: flash_program_erase_sequencer_tb.sv
// Self-checking bench of the flash program and erase sequencer
`timescale 1ns/1ps
`default_nettype none
module flash_program_erase_sequencer_tb import fpes_pkg::*; ;
    logic SYS_CLK, SYS_RST, WR, RD, IRQ, FL_ERASE_PAGE, FL_ERASE_ALL;
    logic FL_PROG_WE, LOCK_REGION_BYTES_WORD_SET;
    logic [ADDR_W-1:0] ADDR;
    logic [31:0] WDATA, RDATA, FL_PROG_DATA, rv, exp_w [64];
    logic [PAGE_W-1:0] FL_PAGE;
    logic [5:0] FL_PROG_ADDR;
    logic [3:0] LOCK_REGION_BYTES_WORD_REGION;
    logic [7:0] p, q, r, r2;
    int n_mismatch, checked, b_prog, b_erp, b_era, b_lock, g, k;
    integer seed = 32'hacc854f1;
    fpes_seq #(.ERASE_CYC(4)) dut (.SYS_CLK(SYS_CLK), .SYS_RST(SYS_RST), .ADDR(ADDR),
        .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .IRQ(IRQ), .FL_PAGE(FL_PAGE),
        .FL_ERASE_PAGE(FL_ERASE_PAGE), .FL_ERASE_ALL(FL_ERASE_ALL), .FL_PROG_WE(FL_PROG_WE),
        .FL_PROG_ADDR(FL_PROG_ADDR), .FL_PROG_DATA(FL_PROG_DATA), .LOCK_REGION_BYTES_WORD_SET(LOCK_REGION_BYTES_WORD_SET),
        .LOCK_REGION_BYTES_WORD_REGION(LOCK_REGION_BYTES_WORD_REGION));
    fpes_flash_model fm (.clk(SYS_CLK), .rst(SYS_RST), .erase_page(FL_ERASE_PAGE),
        .erase_all(FL_ERASE_ALL), .prog_we(FL_PROG_WE), .prog_addr(FL_PROG_ADDR),
        .prog_data(FL_PROG_DATA), .lock_set(LOCK_REGION_BYTES_WORD_SET), .lock_region(LOCK_REGION_BYTES_WORD_REGION));
    initial begin
        SYS_CLK = 1'b0;
        forever #50 SYS_CLK = ~SYS_CLK;
    end
    ////////////////////////////////////////////////////////////////////////////
    // Checking and reporting
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic finish_test();
        $display("Comparisons %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic done_test(input string s);
        $display("Test %s finished", s);
    endtask
    function automatic logic [31:0] desc_w(input int i);
        if (i == 0) return IFACE_DESCR;
        if (i == 1 || i == 4) return 32'h0001_0000;
        if (i == 2) return 32'h0000_0100;
        if (i == 3) return 32'h0000_0001;
        if (i == 5) return 32'h0000_0010;
        if (i <= 21) return 32'h0000_1000;
        return 32'h0;
    endfunction
    ////////////////////////////////////////////////////////////////////////////
    // Register port tasks; strobes last one cycle
    task automatic wr(input logic [20:0] a, input logic [31:0] d);
        @(posedge SYS_CLK);
        ADDR <= a;
        WDATA <= d;
        WR <= 1'b1;
        @(posedge SYS_CLK);
        WR <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] off);
        @(posedge SYS_CLK);
        ADDR <= {1'b1, 12'h000, off};
        RD <= 1'b1;
        @(posedge SYS_CLK);
        RD <= 1'b0;
        #1 rv = RDATA;
    endtask
    task automatic cmd(input logic [7:0] code, input logic [7:0] pg);
        wr({1'b1, 12'h000, OFF_CMD}, {CMD_KEY, 8'h00, pg, code});
    endtask
    // IRQ can still show the previous done, so the first cycles are skipped
    task automatic wait_irq();
        int i;
        repeat (3) @(posedge SYS_CLK);
        for (i = 0; i < 300 && IRQ !== 1'b1; i++) @(posedge SYS_CLK);
        if (i == 300) begin
            n_mismatch++;
            $display("Error irq wait expected 1 seen timeout");
            finish_test();
        end
    endtask
    task automatic fill(input int first, input int cnt);
        logic [11:0] al;
        al = 12'($random(seed));
        for (int i = first; i < first + cnt; i++) begin
            exp_w[i] = $random(seed);
            wr({1'b0, al, 6'(i), 2'b00}, exp_w[i]);
        end
        repeat (20) @(posedge SYS_CLK);
    endtask
    task automatic snap();
        b_prog = fm.n_prog;
        b_erp = fm.n_erp;
        b_era = fm.n_era;
        b_lock = fm.n_lock;
    endtask
    task automatic chk_page();
        for (int i = 0; i < 64; i++) chk("flash word", fm.mem[i], exp_w[i]);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        SYS_RST = 1'b1;
        WR = 1'b0;
        RD = 1'b0;
        ADDR = '0;
        WDATA = '0;
        repeat (10) @(posedge SYS_CLK);
        SYS_RST <= 1'b0;
        rd(OFF_STATUS);
        chk("status after reset", rv, 32'h0);
        wr({1'b1, 12'h000, OFF_MODE}, {20'h0, 2'($random(seed)), 8'h00, 2'b01});
        cmd(CODE_DESC, 8'h00);
        wait_irq();
        for (k = 0; k < 3; k++) rd(OFF_RESULT);
        cmd(CODE_DESC, 8'h00);
        wait_irq();
        rd(OFF_STATUS);
        chk("status desc", rv, 32'h1);
        for (k = 0; k < 24; k++) begin
            rd(OFF_RESULT);
            chk("descriptor word", rv, desc_w(k));
        end
        done_test("descriptor");
        for (k = 0; k < 2; k++) begin
            if (k == 0) wr({1'b1, 12'h000, OFF_CMD}, {CMD_KEY ^ 8'h5a, 16'h0, CODE_DESC});
            else cmd(8'h06, 8'h00);
            repeat (4) @(posedge SYS_CLK);
            rd(OFF_STATUS);
            chk("status bad", rv, 32'h3);
            rd(OFF_STATUS);
            chk("status cleared", rv, 32'h1);
        end
        done_test("bad command");
        snap();
        cmd(CODE_FULL_ERASE, 8'h00);
        wait_irq();
        chk("full erases", 32'(fm.n_era - b_era), 32'h1);
        p = 8'($random(seed));
        fill(0, 64);
        snap();
        cmd(CODE_PROG, p);
        wait_irq();
        chk("page", 32'(FL_PAGE), 32'(p));
        chk("words programmed", 32'(fm.n_prog - b_prog), 32'd64);
        chk_page();
        g = $unsigned($random(seed)) % 16;
        fill(g * 4, 4);
        snap();
        cmd(CODE_PROG, p);
        wait_irq();
        chk("partial words", 32'(fm.n_prog - b_prog), 32'd4);
        chk_page();
        done_test("program");
        q = 8'($random(seed));
        r = {4'($random(seed)), 4'h0};
        r2 = r ^ 8'h80;
        fill(0, 64);
        snap();
        cmd(CODE_ERASE_PROG, q);
        wait_irq();
        chk("page erases", 32'(fm.n_erp - b_erp), 32'h1);
        chk("erase prog words", 32'(fm.n_prog - b_prog), 32'd64);
        chk_page();
        for (k = 0; k < 2; k++) begin
            fill(0, 64);
            snap();
            cmd(k == 0 ? CODE_PROG_LOCK : CODE_ERASE_PROG_LOCK, k == 0 ? r : r2);
            wait_irq();
            chk("locks set", 32'(fm.n_lock - b_lock), 32'h1);
            chk("lock region", 32'(fm.last_region), 32'(k == 0 ? r[7:4] : r2[7:4]));
            chk("lock erases", 32'(fm.n_erp - b_erp), 32'(k));
            chk_page();
        end
        done_test("lock");
        snap();
        for (k = 0; k < 2; k++) begin
            if (k == 0) cmd(CODE_PROG, r + 8'h01);
            else cmd(CODE_FULL_ERASE, 8'h00);
            wait_irq();
            rd(OFF_STATUS);
            chk("status locked", rv, 32'h5);
        end
        chk("locked words", 32'(fm.n_prog - b_prog), 32'h0);
        chk("locked erases", 32'(fm.n_era - b_era), 32'h0);
        done_test("locked");
        wr({1'b1, 12'h000, OFF_MODE}, 32'h0);
        cmd(CODE_DESC, 8'h00);
        repeat (10) @(posedge SYS_CLK);
        chk("irq disabled", 32'(IRQ), 32'h0);
        rd(OFF_STATUS);
        chk("status no irq", rv, 32'h1);
        done_test("irq mask");
        finish_test();
    end
endmodule
`default_nettype wire
